// [hdl/qualified_trigger_pkg.sv]
// constants, field layouts and types shared by the qualified trigger logic
package qualified_trigger_pkg;

  // clock and timing figures
  localparam int          CLK_PERIOD_PS  = 8000;
  localparam int          NARROW_STEP_PS = 2500;
  localparam int          HOLD_MIN_PS    = 25000;
  localparam int          HOLD_ZERO_PS   = 12500;
  localparam longint      MAX_TIME_S     = 20;
  localparam logic [31:0] HOLD_MIN_CYC   = 32'((HOLD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] HOLD_ZERO_CYC  = 32'((HOLD_ZERO_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] MAX_TIME_CYC   = 32'((MAX_TIME_S * 64'd1000000000000) / 64'(CLK_PERIOD_PS));
  localparam logic [31:0] MAX_EVENTS     = 32'h3B9ACA00;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PATTERN = 8'h04;
  localparam logic [7:0] ADDR_LIMIT   = 8'h08;
  localparam logic [7:0] ADDR_HOLDOFF = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_MEASURE = 8'h14;
  localparam logic [7:0] ADDR_DELAY   = 8'h18;

  // field widths and reset values
  localparam int          CTRL_W        = 12;
  localparam int          PATTERN_W     = 6;
  localparam int          STATUS_W      = 8;
  localparam logic [31:0] LIMIT_RESET   = 32'h00000001;
  localparam logic [31:0] HOLDOFF_RESET = 32'h00000000;
  localparam logic [31:0] DELAY_RESET   = 32'h00000000;

  // source indices
  localparam logic [1:0] SRC_CH1 = 2'h0;
  localparam logic [1:0] SRC_CH2 = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_PATTERN, MODE_STATE, MODE_TIMED} mode_e;
  typedef enum logic [1:0] {CMP_OFF, CMP_SMALLER, CMP_GREATER, CMP_SPARE} cmp_e;
  typedef enum logic [1:0] {HOLD_NONE, HOLD_TIME, HOLD_EVENTS, HOLD_SPARE} hold_e;
  typedef enum logic [1:0] {LVL_ANY, LVL_LOW, LVL_HIGH, LVL_SPARE} lvl_e;

  typedef struct packed {
    logic       delay_events;
    logic       pattern_exit;
    hold_e      hold;
    cmp_e       cmp;
    logic       interval;
    logic       slope_fall;
    logic [1:0] src_sel;
    mode_e      mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{1'b0, 1'b0, HOLD_NONE, CMP_OFF, 1'b0, 1'b0, SRC_CH1, MODE_SINGLE};

endpackage

// [hdl/qualified_trigger_logic.sv]
// qualified trigger logic: hold-off, width, pattern and state/time qualification
`timescale 1ns/10ps

// What this block does
// - preset counters count events up to one billion or time up to twenty seconds
// - counters serve hold-off, width comparison and delay after a start condition
// - levels of both channels and external input are sensed for combinations
// - each potential trigger, not acquisition end, starts the hold-off interval
// - accept potential trigger only while armed; ignore it while still busy
// - pulse width is slope to opposite slope; interval is slope to same slope
// - trigger on measured width smaller or greater than the limit, as selected
// - narrow pulse limit counts in 2.5 ns steps, minimum 2.5 ns
// - pattern is the AND of low, high or don't-care per source
// - pattern triggers on entering or on exiting, as selected
// - pattern combines with width and hold-off options; the interval bit is not used in pattern mode
// - entering with width check compares the preceding pattern-false period
// - exiting with width check compares the true period, triggers on exit
// - state mode: entering two-source state starts delay, then source edges trigger
// - state mode: trigger only while state holds; leaving disqualifies
// - state mode: every new entry restarts the delay
// - timed mode: three-source state starts delay; triggering stays enabled afterwards
// - timed mode: further entries do not restart a running or completed delay
// - timed qualification persists until a trigger or a mode rewrite re-arms
// - hold-off by time spans 25 ns to 20 s
// - zero hold-off by time gives the 12.5 ns minimum
module qualified_trigger_logic #(
  parameter logic [31:0] HOLD_MAX_CYC = qualified_trigger_pkg::MAX_TIME_CYC,
  parameter logic [31:0] EVENT_MAX    = qualified_trigger_pkg::MAX_EVENTS
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // thresholded trigger sources
  input  wire logic        ch1_level,
  input  wire logic        ch2_level,
  input  wire logic        ext_level,
  // acquisition side
  input  wire logic        acq_armed,
  output logic             trig_out,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  qualified_trigger_pkg::ctrl_s ctrl_reg, ctrl_next;
  logic [5:0]  pattern_reg, pattern_next;
  logic [31:0] limit_reg, limit_next;
  logic [31:0] holdoff_reg, holdoff_next;
  logic [31:0] delay_reg, delay_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [2:0]  src_prev_reg, src_prev_next;
  logic        pat_prev_reg, pat_prev_next;
  logic        meas_run_reg, meas_run_next;
  logic [31:0] meas_cnt_reg, meas_cnt_next;
  logic [31:0] meas_last_reg, meas_last_next;
  logic        delay_run_reg, delay_run_next;
  logic        delay_done_reg, delay_done_next;
  logic [31:0] delay_cnt_reg, delay_cnt_next;
  logic        hold_busy_reg, hold_busy_next;
  logic [31:0] hold_cnt_reg, hold_cnt_next;
  logic        trig_reg, trig_next;

  logic [2:0]  src;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic [1:0]  sel_idx;
  logic        slope_edge;
  logic        opp_edge;
  logic [2:0]  bit_ok;
  logic [2:0]  src_mask;
  logic        pat_cur;
  logic        enter;
  logic        leave;
  logic        meas_start;
  logic        meas_stop;
  logic        point;
  logic        width_ok;
  logic [63:0] meas_ps;
  logic [63:0] lim_ps;
  logic [31:0] lim_eff;
  logic        potential;
  logic        pot_accept;
  logic        wr_ctrl;
  logic [31:0] hold_load;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  assign src     = {ext_level, ch2_level, ch1_level};
  assign rise    = src & ~src_prev_reg;
  assign fall    = ~src & src_prev_reg;
  assign sel_idx = (ctrl_reg.src_sel == 2'h3) ? qualified_trigger_pkg::SRC_EXT : ctrl_reg.src_sel;
  assign slope_edge = ctrl_reg.slope_fall ? fall[sel_idx] : rise[sel_idx];
  assign opp_edge   = ctrl_reg.slope_fall ? rise[sel_idx] : fall[sel_idx];
  assign wr_ctrl    = reg_wr && (reg_addr == qualified_trigger_pkg::ADDR_CTRL);

  // per-source level check against the programmed low, high or don't-care
  for (genvar i = 0; i < 3; i++) begin : g_src
    assign bit_ok[i] = (pattern_reg[2*i+1 -: 2] == qualified_trigger_pkg::LVL_ANY)
                    || (pattern_reg[2*i+1 -: 2] == qualified_trigger_pkg::LVL_SPARE)
                    || ((pattern_reg[2*i+1 -: 2] == qualified_trigger_pkg::LVL_LOW) && !src[i])
                    || ((pattern_reg[2*i+1 -: 2] == qualified_trigger_pkg::LVL_HIGH) && src[i]);
    assign src_mask[i] = (ctrl_reg.mode == qualified_trigger_pkg::MODE_STATE) && (sel_idx == 2'(i));
  end

  assign pat_cur = &(bit_ok | src_mask);
  assign enter   = pat_cur && !pat_prev_reg;
  assign leave   = !pat_cur && pat_prev_reg;

  // width compare in picoseconds so the limit does not depend on the clock
  assign lim_eff  = (limit_reg == 32'h00000000) ? 32'h00000001 : limit_reg;
  assign meas_ps  = 64'(meas_cnt_reg) * 64'(qualified_trigger_pkg::CLK_PERIOD_PS);
  assign lim_ps   = 64'(lim_eff) * 64'(qualified_trigger_pkg::NARROW_STEP_PS);
  assign width_ok = (ctrl_reg.cmp == qualified_trigger_pkg::CMP_SMALLER) ? (meas_ps < lim_ps)
                  : (ctrl_reg.cmp == qualified_trigger_pkg::CMP_GREATER) ? (meas_ps > lim_ps)
                  : 1'b0;

  // start, stop and trigger point of the measured width
  always_comb begin
    meas_start = 1'b0;
    meas_stop  = 1'b0;
    point      = 1'b0;
    if (ctrl_reg.mode == qualified_trigger_pkg::MODE_PATTERN) begin
      meas_start = ctrl_reg.pattern_exit ? enter : leave;
      meas_stop  = ctrl_reg.pattern_exit ? leave : enter;
      point      = meas_stop;
    end else if (ctrl_reg.mode == qualified_trigger_pkg::MODE_SINGLE) begin
      meas_start = slope_edge;
      meas_stop  = ctrl_reg.interval ? slope_edge : opp_edge;
      point      = slope_edge;
    end
  end

  // potential trigger from whichever mode is active
  always_comb begin
    potential = 1'b0;
    case (ctrl_reg.mode)
      qualified_trigger_pkg::MODE_SINGLE,
      qualified_trigger_pkg::MODE_PATTERN: begin
        if (ctrl_reg.cmp == qualified_trigger_pkg::CMP_OFF) begin
          potential = point;
        end else begin
          potential = meas_stop && meas_run_reg && width_ok;
        end
      end
      qualified_trigger_pkg::MODE_STATE: begin
        potential = delay_done_reg && pat_cur && slope_edge;
      end
      default: begin
        potential = delay_done_reg && slope_edge;
      end
    endcase
  end

  assign pot_accept = potential && !hold_busy_reg;

  // hold-off preset, clamped to the programmable span
  always_comb begin
    hold_load = holdoff_reg;
    if (ctrl_reg.hold == qualified_trigger_pkg::HOLD_TIME) begin
      if (holdoff_reg == 32'h00000000) begin
        hold_load = qualified_trigger_pkg::HOLD_ZERO_CYC;
      end else if (holdoff_reg < qualified_trigger_pkg::HOLD_MIN_CYC) begin
        hold_load = qualified_trigger_pkg::HOLD_MIN_CYC;
      end else if (holdoff_reg > HOLD_MAX_CYC) begin
        hold_load = HOLD_MAX_CYC;
      end
    end else if (holdoff_reg > EVENT_MAX) begin
      hold_load = EVENT_MAX;
    end
  end

  // next state of the whole block
  always_comb begin
    ctrl_next       = ctrl_reg;
    pattern_next    = pattern_reg;
    limit_next      = limit_reg;
    holdoff_next    = holdoff_reg;
    delay_next      = delay_reg;
    rdata_next      = 32'h00000000;
    src_prev_next   = src;
    pat_prev_next   = pat_cur;
    meas_run_next   = meas_run_reg;
    meas_cnt_next   = meas_cnt_reg;
    meas_last_next  = meas_last_reg;
    delay_run_next  = delay_run_reg;
    delay_done_next = delay_done_reg;
    delay_cnt_next  = delay_cnt_reg;
    hold_busy_next  = hold_busy_reg;
    hold_cnt_next   = hold_cnt_reg;
    trig_next       = pot_accept && acq_armed;

    // register writes
    if (reg_wr) begin
      if (reg_addr == qualified_trigger_pkg::ADDR_CTRL) begin
        ctrl_next = qualified_trigger_pkg::ctrl_s'(reg_wdata[qualified_trigger_pkg::CTRL_W-1:0]);
      end else if (reg_addr == qualified_trigger_pkg::ADDR_PATTERN) begin
        pattern_next = reg_wdata[qualified_trigger_pkg::PATTERN_W-1:0];
      end else if (reg_addr == qualified_trigger_pkg::ADDR_LIMIT) begin
        limit_next = reg_wdata;
      end else if (reg_addr == qualified_trigger_pkg::ADDR_HOLDOFF) begin
        holdoff_next = reg_wdata;
      end else if (reg_addr == qualified_trigger_pkg::ADDR_DELAY) begin
        delay_next = reg_wdata;
      end
    end

    // register reads, data in the following cycle only
    if (reg_rd) begin
      if (reg_addr == qualified_trigger_pkg::ADDR_CTRL) begin
        rdata_next = 32'(ctrl_reg);
      end else if (reg_addr == qualified_trigger_pkg::ADDR_PATTERN) begin
        rdata_next = 32'(pattern_reg);
      end else if (reg_addr == qualified_trigger_pkg::ADDR_LIMIT) begin
        rdata_next = limit_reg;
      end else if (reg_addr == qualified_trigger_pkg::ADDR_HOLDOFF) begin
        rdata_next = holdoff_reg;
      end else if (reg_addr == qualified_trigger_pkg::ADDR_STATUS) begin
        rdata_next = 32'({pat_cur, delay_done_reg, delay_run_reg, hold_busy_reg, meas_run_reg, src});
      end else if (reg_addr == qualified_trigger_pkg::ADDR_MEASURE) begin
        rdata_next = meas_last_reg;
      end else if (reg_addr == qualified_trigger_pkg::ADDR_DELAY) begin
        rdata_next = delay_reg;
      end
    end

    // width measurement, saturating count of clock cycles
    if (meas_run_reg && (meas_cnt_reg != 32'hFFFFFFFF)) begin
      meas_cnt_next = meas_cnt_reg + 32'h00000001;
    end
    if (meas_stop && meas_run_reg) begin
      meas_last_next = meas_cnt_reg;
      meas_run_next  = 1'b0;
    end
    if (meas_start) begin
      meas_run_next = 1'b1;
      meas_cnt_next = 32'h00000001;
    end

    // qualification delay by time or by source events
    if (delay_run_reg && (!ctrl_reg.delay_events || slope_edge)) begin
      delay_cnt_next = delay_cnt_reg + 32'h00000001;
      if ((delay_cnt_reg + 32'h00000001) >= delay_reg) begin
        delay_run_next  = 1'b0;
        delay_done_next = 1'b1;
      end
    end
    if (ctrl_reg.mode == qualified_trigger_pkg::MODE_STATE) begin
      if (leave) begin
        delay_run_next  = 1'b0;
        delay_done_next = 1'b0;
      end else if (enter) begin
        delay_cnt_next  = 32'h00000000;
        delay_run_next  = (delay_reg != 32'h00000000);
        delay_done_next = (delay_reg == 32'h00000000);
      end
    end else if (ctrl_reg.mode == qualified_trigger_pkg::MODE_TIMED) begin
      if (enter && !delay_run_reg && !delay_done_reg) begin
        delay_cnt_next  = 32'h00000000;
        delay_run_next  = (delay_reg != 32'h00000000);
        delay_done_next = (delay_reg == 32'h00000000);
      end
      if (trig_next) begin
        delay_done_next = 1'b0;
      end
    end else begin
      delay_run_next  = 1'b0;
      delay_done_next = 1'b0;
    end

    // hold-off, started by every potential trigger that gets through
    if (hold_busy_reg) begin
      if ((ctrl_reg.hold == qualified_trigger_pkg::HOLD_TIME) || potential) begin
        hold_cnt_next = hold_cnt_reg - 32'h00000001;
        if (hold_cnt_reg <= 32'h00000001) begin
          hold_busy_next = 1'b0;
        end
      end
    end else if (pot_accept && (ctrl_reg.hold != qualified_trigger_pkg::HOLD_NONE)
                 && (hold_load != 32'h00000000)) begin
      hold_busy_next = 1'b1;
      hold_cnt_next  = hold_load;
    end

    // a mode rewrite stops and re-arms all qualification
    if (wr_ctrl) begin
      meas_run_next   = 1'b0;
      delay_run_next  = 1'b0;
      delay_done_next = 1'b0;
      hold_busy_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg       <= qualified_trigger_pkg::CTRL_RESET;
      pattern_reg    <= '0;
      limit_reg      <= qualified_trigger_pkg::LIMIT_RESET;
      holdoff_reg    <= qualified_trigger_pkg::HOLDOFF_RESET;
      delay_reg      <= qualified_trigger_pkg::DELAY_RESET;
      rdata_reg      <= '0;
      src_prev_reg   <= '0;
      pat_prev_reg   <= 1'b0;
      meas_run_reg   <= 1'b0;
      meas_cnt_reg   <= '0;
      meas_last_reg  <= '0;
      delay_run_reg  <= 1'b0;
      delay_done_reg <= 1'b0;
      delay_cnt_reg  <= '0;
      hold_busy_reg  <= 1'b0;
      hold_cnt_reg   <= '0;
      trig_reg       <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      pattern_reg    <= pattern_next;
      limit_reg      <= limit_next;
      holdoff_reg    <= holdoff_next;
      delay_reg      <= delay_next;
      rdata_reg      <= rdata_next;
      src_prev_reg   <= src_prev_next;
      pat_prev_reg   <= pat_prev_next;
      meas_run_reg   <= meas_run_next;
      meas_cnt_reg   <= meas_cnt_next;
      meas_last_reg  <= meas_last_next;
      delay_run_reg  <= delay_run_next;
      delay_done_reg <= delay_done_next;
      delay_cnt_reg  <= delay_cnt_next;
      hold_busy_reg  <= hold_busy_next;
      hold_cnt_reg   <= hold_cnt_next;
      trig_reg       <= trig_next;
    end
  end

  assign trig_out  = trig_reg;
  assign reg_rdata = rdata_reg;

  sequence busy_for_two;
    hold_busy_reg [*2] ##1 !hold_busy_reg;
  endsequence

  sequence busy_for_four;
    hold_busy_reg [*4] ##1 !hold_busy_reg;
  endsequence

  accept_armed_a: assert property (trig_reg |-> $past(acq_armed))
    else $error("trigger issued while not armed");
  hold_block_a: assert property (trig_reg |-> !$past(hold_busy_reg))
    else $error("trigger issued during hold-off");
  hold_start_a: assert property (pot_accept && !wr_ctrl && (ctrl_reg.hold == qualified_trigger_pkg::HOLD_TIME)
                                 |=> hold_busy_reg)
    else $error("hold-off not started by potential trigger");
  hold_zero_a: assert property (pot_accept && !reg_wr && (ctrl_reg.hold == qualified_trigger_pkg::HOLD_TIME)
                                && (holdoff_reg == 32'h00000000) |=> busy_for_two)
    else $error("zero hold-off is not two cycles");
  hold_min_a: assert property (pot_accept && !reg_wr && (ctrl_reg.hold == qualified_trigger_pkg::HOLD_TIME)
                               && (holdoff_reg != 32'h00000000) && (holdoff_reg < qualified_trigger_pkg::HOLD_MIN_CYC)
                               |=> busy_for_four)
    else $error("short hold-off not raised to minimum");
  state_leave_a: assert property ((ctrl_reg.mode == qualified_trigger_pkg::MODE_STATE) && leave
                                  |=> !delay_done_reg ##1 !trig_reg)
    else $error("state mode still qualified after leaving");
  state_restart_a: assert property ((ctrl_reg.mode == qualified_trigger_pkg::MODE_STATE) && enter && !reg_wr
                                    && (delay_reg != 32'h00000000)
                                    |=> delay_run_reg && (delay_cnt_reg == 32'h0))
    else $error("state entry did not restart delay");
  timed_keep_a: assert property ((ctrl_reg.mode == qualified_trigger_pkg::MODE_TIMED) && delay_done_reg
                                 && !trig_next && !wr_ctrl |=> delay_done_reg)
    else $error("timed qualification dropped without trigger");
  pattern_enter_a: assert property ((ctrl_reg.mode == qualified_trigger_pkg::MODE_PATTERN) && enter && acq_armed
                                    && !ctrl_reg.pattern_exit && (ctrl_reg.cmp == qualified_trigger_pkg::CMP_OFF)
                                    && !hold_busy_reg |=> trig_reg)
    else $error("pattern entry gave no trigger");

endmodule // qualified_trigger_logic

// [bench/source_model.sv]
// far-side model: thresholded trigger sources and acquisition control
`timescale 1ns/10ps
module source_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // bench control
  input  wire logic       run,
  input  wire logic [3:0] stim,
  // trigger handshake
  input  wire logic       trig_out,
  output logic            acq_armed,
  // source levels
  output logic            ch1_level,
  output logic            ch2_level,
  output logic            ext_level
);
  logic [2:0] lv_reg   = 3'h0;
  logic [1:0] busy_reg = 2'h0;

  initial acq_armed = 1'b1;
  assign ch1_level = lv_reg[0];
  assign ch2_level = lv_reg[1];
  assign ext_level = lv_reg[2];

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lv_reg <= 3'h0;
      busy_reg <= 2'h0;
      acq_armed <= 1'b1;
    end else begin
      // busy for one or two cycles after each trigger, then re-armed
      if (busy_reg != 2'h0) begin
        busy_reg <= busy_reg - 2'h1;
      end else if (trig_out) begin
        acq_armed <= 1'b0;
        busy_reg <= {1'b0, stim[2]} + 2'h1;
      end else begin
        acq_armed <= 1'b1;
      end
      // random level flips while running, all low when idle
      if (!run) begin
        lv_reg <= 3'h0;
      end else if (!stim[3] && stim[1:0] != 2'h3) begin
        lv_reg[stim[1:0]] <= ~lv_reg[stim[1:0]];
      end
    end
  end
endmodule // source_model

// [bench/testbench.sv]
// self-checking bench for the qualified trigger logic
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        run       = 1'b0;
  logic [3:0]  stim      = 4'h0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  wire  [31:0] reg_rdata;
  wire         ch1_level, ch2_level, ext_level, acq_armed, trig_out;
  integer      seed      = 32'h2B49EF92;
  int          fails     = 0;
  int          checked   = 0;
  logic [11:0] c_ctrl    = 12'h000;
  logic [5:0]  c_pat     = 6'h00;
  logic [31:0] c_lim     = 32'h00000001;
  logic [31:0] c_hold    = 32'h00000000;
  logic        exp_trig  = 1'b0;
  int          hb        = 0;
  int          ev        = 0;
  int          run_len   = 0;
  logic [2:0]  pl        = 3'h0;
  int          dc        = 0;
  int          pr        = 0;
  logic        dr        = 1'b0;
  logic        qd        = 1'b0;
  // ctrl, pattern, limit, hold-off
  logic [35:0] cfg [15] = '{36'h000000100, 36'h114000100, 36'h108000102, 36'h100000109, 36'h200000103,
                            36'h040000700, 36'h080000A00, 36'h001060100, 36'h401200100, 36'h441260D00,
                            36'h101060105, 36'h00A090103, 36'h80A090102, 36'h00B290105, 36'h0A0090A00};

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) stim <= 4'($random(seed));

  qualified_trigger_logic #(.HOLD_MAX_CYC(32'h00000040), .EVENT_MAX(32'h00000040)) i_qualified_trigger_logic (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ch1_level(ch1_level), .ch2_level(ch2_level), .ext_level(ext_level),
    .acq_armed(acq_armed), .trig_out(trig_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  source_model i_source_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .run(run), .stim(stim), .trig_out(trig_out), .acq_armed(acq_armed),
    .ch1_level(ch1_level), .ch2_level(ch2_level), .ext_level(ext_level));

  // tracked signal: pattern truth in pattern mode, else the selected source seen as rising
  function automatic logic qp(logic [2:0] lv);
    logic p;
    int   k;
    p = 1'b1;
    for (k = 0; k < 3; k++) begin
      if (!(c_ctrl[1:0] == 2'h2 && k == ((c_ctrl[3:2] > 2'h2) ? 2 : int'(c_ctrl[3:2])))
          && ((c_pat[2*k+:2] == 2'h1 && lv[k]) || (c_pat[2*k+:2] == 2'h2 && !lv[k]))) p = 1'b0;
    end
    return p;
  endfunction

  function automatic logic sig(logic [2:0] lv);
    int   k;
    k = (c_ctrl[3:2] > 2'h2) ? 2 : int'(c_ctrl[3:2]);
    return (c_ctrl[1:0] == 2'h1) ? qp(lv) : lv[k] ^ c_ctrl[4];
  endfunction

  always @(posedge clk_sys) begin : model
    logic [2:0] lv;
    logic       s, chg, hit, ok, rise_ev, busy;
    int         lim;
    int         w;
    if (sys_rst) begin
      exp_trig = 1'b0;
      dc = 0;
      pr = 0;
      dr = 1'b0;
      qd = 1'b0;
      hb = 0;
      ev = 0;
      run_len = 0;
      pl = 3'h0;
    end else begin
      `CHK(trig_out, exp_trig)
      lv = {ext_level, ch2_level, ch1_level};
      s = sig(lv);
      chg = s != sig(pl);
      rise_ev = (c_ctrl[1:0] != 2'h1 && (c_ctrl[7:6] == 2'h0 || c_ctrl[7:6] == 2'h3 || c_ctrl[5]))
                || (c_ctrl[1:0] == 2'h1 && !c_ctrl[10]);
      hit = chg && (s == rise_ev);
      if (c_ctrl[1:0] >= 2'h2) hit = hit && qd && (qp(lv) || c_ctrl[0]);
      lim = (c_lim == 0) ? 1 : int'(c_lim);
      w = (c_ctrl[1:0] == 2'h0 && c_ctrl[5]) ? pr : run_len;
      ok = (c_ctrl[7:6] == 2'h1) ? (w * 8000 < lim * 2500)
         : (c_ctrl[7:6] == 2'h2) ? (w * 8000 > lim * 2500) : 1'b1;
      run_len = chg ? 1 : run_len + 1;
      pr = (chg && s) ? 1 : (pr != 0) ? pr + 1 : 0;
      busy = hb != 0;
      if (hb != 0) hb--;
      exp_trig = 1'b0;
      if (hit && ok) begin
        if (busy || ev != 0) begin
          if (ev != 0) ev--;
        end else begin
          exp_trig = acq_armed;
          hb = (c_ctrl[9:8] != 2'h1) ? 0 : (c_hold == 0) ? 2 : (c_hold < 4) ? 4 : (c_hold > 64) ? 64 : int'(c_hold);
          ev = (c_ctrl[9:8] >= 2'h2) ? int'(c_hold) : 0;
        end
      end
      if (dr && (!c_ctrl[11] || (chg && s))) begin
        dc++;
        if (dc >= int'(c_hold)) begin
          dr = 1'b0;
          qd = 1'b1;
        end
      end
      if (c_ctrl[1:0] == 2'h2 && !qp(lv) && qp(pl)) begin
        dr = 1'b0;
        qd = 1'b0;
      end else if (qp(lv) && !qp(pl) && (c_ctrl[1:0] == 2'h2 || (c_ctrl[1:0] == 2'h3 && !dr && !qd))) begin
        dc = 0;
        dr = c_hold != 0;
        qd = c_hold == 0;
      end
      if (c_ctrl[1:0] == 2'h3 && exp_trig) qd = 1'b0;
      if (c_ctrl[1:0] < 2'h2) begin
        dr = 1'b0;
        qd = 1'b0;
      end
      if (reg_wr && reg_addr == qualified_trigger_pkg::ADDR_CTRL) begin
        hb = 0;
        ev = 0;
        pr = 0;
        dr = 1'b0;
        qd = 1'b0;
      end
      pl = lv;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  task automatic chk_regs();
    rd(qualified_trigger_pkg::ADDR_CTRL, {20'h00000, c_ctrl});
    rd(qualified_trigger_pkg::ADDR_PATTERN, {26'h0000000, c_pat});
    rd(qualified_trigger_pkg::ADDR_LIMIT, c_lim);
    rd(qualified_trigger_pkg::ADDR_HOLDOFF, c_hold);
    rd(qualified_trigger_pkg::ADDR_DELAY, c_hold);
  endtask

  initial begin : watchdog
    repeat (100000) @(posedge clk_sys);
    fails++;
    summarize();
  end

  initial begin : main
    int i;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_regs();
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h00000000);
    for (i = 0; i < 15; i++) begin
      c_ctrl = cfg[i][35:24];
      c_pat = cfg[i][21:16];
      c_lim = {24'h000000, cfg[i][15:8]};
      c_hold = {24'h000000, cfg[i][7:0]};
      wr(qualified_trigger_pkg::ADDR_PATTERN, {26'h0000000, c_pat});
      wr(qualified_trigger_pkg::ADDR_LIMIT, c_lim);
      wr(qualified_trigger_pkg::ADDR_HOLDOFF, c_hold);
      wr(qualified_trigger_pkg::ADDR_DELAY, c_hold);
      wr(qualified_trigger_pkg::ADDR_CTRL, {20'h00000, c_ctrl});
      chk_regs();
      run <= 1'b1;
      repeat (400) @(posedge clk_sys);
      run <= 1'b0;
      repeat (20) @(posedge clk_sys);
    end
    run <= 1'b1;
    repeat (50) @(posedge clk_sys);
    sys_rst <= 1'b1;
    c_ctrl = 12'h000;
    c_pat = 6'h00;
    c_lim = 32'h00000001;
    c_hold = 32'h00000000;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (200) @(posedge clk_sys);
    run <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk_regs();
    summarize();
  end
endmodule // testbench
